// ==== hw/ref_freq_monitor_config.sv ====
// Frequency monitor configuration bank with Wishbone slave, alarms and phase build-out control
module ref_freq_monitor_config #(
  parameter int N_INPUTS = 14
) (
  // Clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // Wishbone slave
  input  wire logic                                cyc_i,
  input  wire logic                                stb_i,
  input  wire logic                                we_i,
  input  wire logic [9:0]                          adr_i,
  input  wire logic [3:0]                          sel_i,
  input  wire logic [31:0]                         dat_i,
  output logic [31:0]                              dat_o,
  output logic                                     ack_o,
  // Monitor measurements, one offset per input
  input  wire logic [N_INPUTS*rfm_pkg::OFS_W-1:0]  offset_i,
  input  wire logic [N_INPUTS-1:0]                 offset_valid_i,
  // Timing loop selection state
  input  wire logic [3:0]                          sel_source_i,
  input  wire logic                                holdover_i,
  input  wire logic                                free_run_i,
  // Timing loop controls
  output logic                                     pbo_event_o,
  output logic                                     zero_phase_lock_o,
  output logic [N_INPUTS-1:0]                      disqualify_o,
  output logic [N_INPUTS-1:0]                      soft_alarm_o,
  output logic [N_INPUTS-1:0]                      hard_alarm_o,
  // Interrupt
  output logic                                     irq_o
);

  // ==========================================================================
  // Registers
  logic [7:0]                  ctrl_q, ctrl_d;
  logic [7:0]                  limits_q, limits_d;
  logic [rfm_pkg::IRQ_W-1:0]   stat_q, stat_d;
  logic [rfm_pkg::IRQ_W-1:0]   mask_q, mask_d;
  logic [31:0]                 rdata_d;
  logic                        ack_d;
  logic [3:0]                  src_q;
  logic                        hold_q;
  logic                        pbo_d;
  logic [N_INPUTS-1:0]         soft_w, hard_w, soft_prev_q, hard_prev_q;
  logic [7:0]                  idx;
  logic                        wr, rd;

  assign idx = adr_i[9:2];
  assign wr  = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign rd  = cyc_i && stb_i && !ack_o;

  // ==========================================================================
  // Monitors
  genvar g;
  generate
    for (g = 0; g < N_INPUTS; g++)
    begin : g_mon
      freq_limit_check u_chk (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .offset_i     (offset_i[g*rfm_pkg::OFS_W +: rfm_pkg::OFS_W]),
        .valid_i      (offset_valid_i[g]),
        .soft_lim_i   (limits_q[rfm_pkg::SOFT_LIM_LSB +: 4]),
        .hard_lim_i   (limits_q[rfm_pkg::HARD_LIM_LSB +: 4]),
        .soft_en_i    (ctrl_q[rfm_pkg::BIT_SOFT_EN]),
        .hard_en_i    (ctrl_q[rfm_pkg::BIT_HARD_EN]),
        .soft_alarm_o (soft_w[g]),
        .hard_alarm_o (hard_w[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Register file and phase build-out
  always_comb
  begin
    ctrl_d   = ctrl_q;
    limits_d = limits_q;
    mask_d   = mask_q;
    stat_d   = stat_q;
    rdata_d  = 32'h0000_0000;
    ack_d    = rd;
    // Source change or exit from holdover/free-run both count as a new selection
    pbo_d    = ctrl_q[rfm_pkg::BIT_BUILDOUT_EN] &&
               ((sel_source_i != src_q) || (hold_q && !(holdover_i || free_run_i)));
    if (wr)
    begin
      unique case (idx)
        rfm_pkg::IDX_MON_CTRL:     ctrl_d   = {5'h00, dat_i[2:0]};
        rfm_pkg::IDX_ALARM_LIMITS: limits_d = dat_i[7:0];
        rfm_pkg::IDX_ALARM_MASK:   mask_d   = dat_i[rfm_pkg::IRQ_W-1:0];
        rfm_pkg::IDX_ALARM_STAT:   stat_d   = stat_q & ~dat_i[rfm_pkg::IRQ_W-1:0];
        default:                   ;
      endcase
    end
    // Set wins over a clear in the same cycle
    stat_d[rfm_pkg::IRQ_PBO]  = stat_d[rfm_pkg::IRQ_PBO] | pbo_d;
    stat_d[rfm_pkg::IRQ_SOFT] = stat_d[rfm_pkg::IRQ_SOFT] | (|(soft_w & ~soft_prev_q));
    stat_d[rfm_pkg::IRQ_HARD] = stat_d[rfm_pkg::IRQ_HARD] | (|(hard_w & ~hard_prev_q));
    if (rd && !we_i)
    begin
      if (idx == rfm_pkg::IDX_MON_CTRL)
        rdata_d = {24'h00_0000, ctrl_q};
      else if (idx == rfm_pkg::IDX_ALARM_LIMITS)
        rdata_d = {24'h00_0000, limits_q};
      else if (idx == rfm_pkg::IDX_ALARM_STAT)
        rdata_d = {29'h0, stat_q};
      else if (idx == rfm_pkg::IDX_ALARM_MASK)
        rdata_d = {29'h0, mask_q};
      else
      begin
        for (int p = 0; p < N_INPUTS / 2; p++)
        begin
          // Pair p: soft/hard of inputs 2p and 2p+1
          if (idx == rfm_pkg::IDX_PAIR_STAT0 + 8'(p))
            rdata_d = {28'h000_0000, soft_w[2*p+1], hard_w[2*p+1], soft_w[2*p], hard_w[2*p]};
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q            <= rfm_pkg::CTRL_RESET;
      limits_q          <= rfm_pkg::LIMITS_RESET;
      stat_q            <= '0;
      mask_q            <= '0;
      dat_o             <= 32'h0000_0000;
      ack_o             <= 1'b0;
      src_q             <= 4'h0;
      hold_q            <= 1'b0;
      pbo_event_o       <= 1'b0;
      zero_phase_lock_o <= 1'b0;
      disqualify_o      <= '0;
      soft_alarm_o      <= '0;
      hard_alarm_o      <= '0;
      soft_prev_q       <= '0;
      hard_prev_q       <= '0;
      irq_o             <= 1'b0;
    end
    else
    begin
      ctrl_q            <= ctrl_d;
      limits_q          <= limits_d;
      stat_q            <= stat_d;
      mask_q            <= mask_d;
      dat_o             <= rdata_d;
      ack_o             <= ack_d;
      src_q             <= sel_source_i;
      hold_q            <= holdover_i || free_run_i;
      pbo_event_o       <= pbo_d;
      zero_phase_lock_o <= !ctrl_d[rfm_pkg::BIT_BUILDOUT_EN];
      disqualify_o      <= hard_w;
      soft_alarm_o      <= soft_w;
      hard_alarm_o      <= hard_w;
      soft_prev_q       <= soft_w;
      hard_prev_q       <= hard_w;
      irq_o             <= |(stat_d & mask_d);
    end
  end

  // ==========================================================================
  // Assertions
  property p_pbo_on_switch;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_q[rfm_pkg::BIT_BUILDOUT_EN] && $changed(sel_source_i)) |=> pbo_event_o;
  endproperty
  a_pbo_on_switch: assert property (p_pbo_on_switch) else $error("no build-out on switch");

  property p_pbo_exit_hold;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_q[rfm_pkg::BIT_BUILDOUT_EN] && hold_q && !holdover_i && !free_run_i) |=> pbo_event_o;
  endproperty
  a_pbo_exit_hold: assert property (p_pbo_exit_hold) else $error("no build-out on holdover exit");

  property p_zero_phase;
    @(posedge clk_i) disable iff (rst_i)
      !ctrl_q[rfm_pkg::BIT_BUILDOUT_EN] |-> (zero_phase_lock_o && !pbo_event_o) or $changed(ctrl_q);
  endproperty
  a_zero_phase: assert property (p_zero_phase) else $error("zero phase lock wrong");

  property p_soft_off;
    @(posedge clk_i) disable iff (rst_i)
      !ctrl_q[rfm_pkg::BIT_SOFT_EN] ##1 !ctrl_q[rfm_pkg::BIT_SOFT_EN] |=> soft_alarm_o == '0;
  endproperty
  a_soft_off: assert property (p_soft_off) else $error("soft alarm while disabled");

  property p_hard_off;
    @(posedge clk_i) disable iff (rst_i)
      !ctrl_q[rfm_pkg::BIT_HARD_EN] ##1 !ctrl_q[rfm_pkg::BIT_HARD_EN] |=> hard_alarm_o == '0;
  endproperty
  a_hard_off: assert property (p_hard_off) else $error("hard alarm while disabled");

  property p_reset_vals;
    @(posedge clk_i) $fell(rst_i) |-> ctrl_q == 8'h05 && limits_q == 8'h23;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_soft_no_dq;
    @(posedge clk_i) disable iff (rst_i) disqualify_o == hard_alarm_o;
  endproperty
  a_soft_no_dq: assert property (p_soft_no_dq) else $error("disqualify not from hard alarm");

  sequence s_hard_rise;
    $rose(hard_w[0]);
  endsequence
  property p_hard_dq;
    @(posedge clk_i) disable iff (rst_i) s_hard_rise |=> disqualify_o[0] && stat_q[rfm_pkg::IRQ_HARD];
  endproperty
  a_hard_dq: assert property (p_hard_dq) else $error("hard alarm did not disqualify");

  // ==========================================================================
  // Bus handshake
  // A request is only new while ack is low, so a held request is answered every second cycle
  sequence s_bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
      s_bus_req |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_ack_idle;
    @(posedge clk_i) disable iff (rst_i)
      !(cyc_i && stb_i) |=> !ack_o;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

  property p_unmapped_read;
    @(posedge clk_i) disable iff (rst_i)
      (rd && !we_i && idx == 8'h7F) |=> dat_o == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // ==========================================================================
  // Register contents
  sequence s_ctrl_write;
    wr && idx == rfm_pkg::IDX_MON_CTRL;
  endsequence

  property p_ctrl_write;
    @(posedge clk_i) disable iff (rst_i)
      s_ctrl_write |=> ctrl_q == {5'h00, $past(dat_i[2:0])};
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_ctrl_hold;
    @(posedge clk_i) disable iff (rst_i)
      !(wr && idx == rfm_pkg::IDX_MON_CTRL) |=> $stable(ctrl_q);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");

  property p_limits_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr && idx == rfm_pkg::IDX_ALARM_LIMITS) |=> limits_q == $past(dat_i[7:0]);
  endproperty
  a_limits_write: assert property (p_limits_write) else $error("limit write lost");

  property p_limits_hold;
    @(posedge clk_i) disable iff (rst_i)
      !(wr && idx == rfm_pkg::IDX_ALARM_LIMITS) |=> $stable(limits_q);
  endproperty
  a_limits_hold: assert property (p_limits_hold) else $error("limits changed without write");

  // ==========================================================================
  // Alarms, status and interrupt
  property p_soft_only_no_dq;
    @(posedge clk_i) disable iff (rst_i)
      (soft_w[0] && !hard_w[0]) |=> !disqualify_o[0];
  endproperty
  a_soft_only_no_dq: assert property (p_soft_only_no_dq) else $error("soft alarm disqualified");

  property p_pair_read;
    @(posedge clk_i) disable iff (rst_i)
      (rd && !we_i && idx == rfm_pkg::IDX_PAIR_STAT0) |=>
        dat_o[3:0] == $past({soft_w[1], hard_w[1], soft_w[0], hard_w[0]});
  endproperty
  a_pair_read: assert property (p_pair_read) else $error("pair status wrong");

  property p_hard_stat_set;
    @(posedge clk_i) disable iff (rst_i)
      (|(hard_w & ~hard_prev_q)) |=> stat_q[rfm_pkg::IRQ_HARD];
  endproperty
  a_hard_stat_set: assert property (p_hard_stat_set) else $error("hard status not set");

  property p_hard_stat_sticky;
    @(posedge clk_i) disable iff (rst_i)
      (stat_q[rfm_pkg::IRQ_HARD] && !(wr && idx == rfm_pkg::IDX_ALARM_STAT && dat_i[rfm_pkg::IRQ_HARD]))
        |=> stat_q[rfm_pkg::IRQ_HARD];
  endproperty
  a_hard_stat_sticky: assert property (p_hard_stat_sticky) else $error("hard status lost");

  // Interrupt follows the registered status, so it lags nothing the bus can read
  property p_irq_level;
    @(posedge clk_i) disable iff (rst_i)
      irq_o == |(stat_q & mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  // ==========================================================================
  // Build-out
  property p_pbo_quiet;
    @(posedge clk_i) disable iff (rst_i)
      !ctrl_q[rfm_pkg::BIT_BUILDOUT_EN] |=> !pbo_event_o;
  endproperty
  a_pbo_quiet: assert property (p_pbo_quiet) else $error("build-out while disabled");

  property p_pbo_no_cause;
    @(posedge clk_i) disable iff (rst_i)
      (!$changed(sel_source_i) && !(hold_q && !holdover_i && !free_run_i)) |=> !pbo_event_o;
  endproperty
  a_pbo_no_cause: assert property (p_pbo_no_cause) else $error("build-out without switch");

  property p_zero_track;
    @(posedge clk_i) disable iff (rst_i)
      zero_phase_lock_o == !ctrl_q[rfm_pkg::BIT_BUILDOUT_EN];
  endproperty
  a_zero_track: assert property (p_zero_track) else $error("zero phase lock not tracking");

  property p_hold_exit_once;
    @(posedge clk_i) disable iff (rst_i)
      (hold_q && !holdover_i && !free_run_i) |=> !hold_q;
  endproperty
  a_hold_exit_once: assert property (p_hold_exit_once) else $error("holdover exit not recorded");

endmodule : ref_freq_monitor_config

// ==== hw/rfm_pkg.sv ====
// Package of register map, field positions, reset values and scaling for the frequency monitor configuration
package rfm_pkg;

  // ==========================================================================
  // Register indices (byte address = 4 * index)
  localparam logic [7:0] IDX_MON_CTRL     = 8'h48;
  localparam logic [7:0] IDX_ALARM_LIMITS = 8'h49;
  localparam logic [7:0] IDX_ALARM_STAT   = 8'h4C;
  localparam logic [7:0] IDX_ALARM_MASK   = 8'h4D;
  localparam logic [7:0] IDX_PAIR_STAT0   = 8'h50;

  // ==========================================================================
  // Control fields
  localparam int         BIT_BUILDOUT_EN = 2;
  localparam int         BIT_SOFT_EN   = 1;
  localparam int         BIT_HARD_EN   = 0;
  localparam logic [7:0] CTRL_RESET    = 8'h05;
  localparam int         SOFT_LIM_LSB  = 4;
  localparam int         HARD_LIM_LSB  = 0;
  localparam logic [7:0] LIMITS_RESET  = 8'h23;

  // ==========================================================================
  // Limit scaling: (field + 1) * 3.81 ppm, offsets measured in units of 0.01 ppm
  localparam int         PPM_STEP_CENTI = 381;
  localparam int         OFS_W          = 16;

  // ==========================================================================
  // Interrupt status bits
  localparam int         IRQ_PBO   = 0;
  localparam int         IRQ_SOFT  = 1;
  localparam int         IRQ_HARD  = 2;
  localparam int         IRQ_W     = 3;

endpackage : rfm_pkg

// ==== hw/freq_limit_check.sv ====
// One input monitor: compares offset magnitude with decoded soft and hard limits
module freq_limit_check (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Measured offset, signed, 0.01 ppm units
  input  wire logic signed [rfm_pkg::OFS_W-1:0] offset_i,
  input  wire logic                       valid_i,
  // Limit fields and enables
  input  wire logic [3:0]                 soft_lim_i,
  input  wire logic [3:0]                 hard_lim_i,
  input  wire logic                       soft_en_i,
  input  wire logic                       hard_en_i,
  // Alarms
  output logic                            soft_alarm_o,
  output logic                            hard_alarm_o
);

  logic [rfm_pkg::OFS_W-1:0] mag;
  logic [rfm_pkg::OFS_W-1:0] soft_lim;
  logic [rfm_pkg::OFS_W-1:0] hard_lim;
  logic                      soft_d, hard_d;

  always_comb
  begin
    mag      = offset_i[rfm_pkg::OFS_W-1] ? rfm_pkg::OFS_W'(-offset_i) : rfm_pkg::OFS_W'(offset_i);
    soft_lim = rfm_pkg::OFS_W'((32'(soft_lim_i) + 32'd1) * rfm_pkg::PPM_STEP_CENTI);
    hard_lim = rfm_pkg::OFS_W'((32'(hard_lim_i) + 32'd1) * rfm_pkg::PPM_STEP_CENTI);
    soft_d   = soft_alarm_o;
    hard_d   = hard_alarm_o;
    if (valid_i)
    begin
      soft_d = soft_en_i && (mag > soft_lim);
      hard_d = hard_en_i && (mag > hard_lim);
    end
    if (!soft_en_i)
      soft_d = 1'b0;
    if (!hard_en_i)
      hard_d = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      soft_alarm_o <= 1'b0;
      hard_alarm_o <= 1'b0;
    end
    else
    begin
      soft_alarm_o <= soft_d;
      hard_alarm_o <= hard_d;
    end
  end

endmodule : freq_limit_check

// ==== sim/ref_src_model.sv ====
// Behavioural model of the monitored input reference sources
module ref_src_model #(
  parameter int N = 14
) (
  // Clock
  input  wire logic                          clk_i,
  // Measurements
  output logic [N*rfm_pkg::OFS_W-1:0]        offset_o,
  output logic [N-1:0]                       valid_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // State
  logic signed [rfm_pkg::OFS_W-1:0] ofs [N];
  int                               gap = 1;
  int                               cnt = 0;
  initial
  begin
    foreach (ofs[k]) ofs[k] = '0;
    offset_o = '0;
    valid_o = '0;
  end
  // ==========================================================================
  // Strobe every gap cycles; lines show the inverse between strobes so a stale sample shows
  always @(posedge clk_i)
  begin
    cnt <= (cnt + 1 >= gap) ? 0 : cnt + 1;
    for (int k = 0; k < N; k++)
    begin
      valid_o[k] <= (cnt == 0);
      offset_o[k*rfm_pkg::OFS_W +: rfm_pkg::OFS_W] <= (cnt == 0) ? ofs[k] : ~ofs[k];
    end
  end
endmodule : ref_src_model

// ==== sim/test_ref_freq_monitor_config.sv ====
// Self-checking bench for the frequency monitor configuration bank
module test_ref_freq_monitor_config;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = 14;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, hold_i = 0, free_i = 0;
  logic [9:0]  adr_i = '0;
  logic [3:0]  sel_i = '0, src_i = '0;
  logic [31:0] dat_i = '0, dat_o;
  logic        ack_o, pbo_o, zpl_o, irq_o;
  logic [N-1:0] dq_o, soft_o, hard_o, val;
  logic [N*rfm_pkg::OFS_W-1:0] ofs;
  int err_count = 0, comparisons = 0;
  logic [7:0] q, lim, ctl;
  always #4 clk_i = ~clk_i;
  ref_src_model #(.N(N)) src (.clk_i(clk_i), .offset_o(ofs), .valid_o(val));
  ref_freq_monitor_config #(.N_INPUTS(N)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .offset_i(ofs), .offset_valid_i(val), .sel_source_i(src_i), .holdover_i(hold_i),
    .free_run_i(free_i), .pbo_event_o(pbo_o), .zero_phase_lock_o(zpl_o), .disqualify_o(dq_o),
    .soft_alarm_o(soft_o), .hard_alarm_o(hard_o), .irq_o(irq_o));
  // ==========================================================================
  // Checks and expectations
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic alarm(input int off, input logic [3:0] f, input logic en);
    return en && ((off < 0 ? -off : off) > (int'(f) + 1) * rfm_pkg::PPM_STEP_CENTI);
  endfunction : alarm
  task automatic tally_and_finish;
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Classic single-cycle bus access; waits for ack, bounded
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= {idx, 2'b00}; sel_i <= 4'hF; dat_i <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 40);
    if (n >= 40) chk(0, 1);
    r = dat_o[7:0];
    cyc_i <= 0; stb_i <= 0;
    @(posedge clk_i);
  endtask : wb
  // Apply offsets, let them settle, compare alarm vectors with expectations
  task automatic alarms(input int off [N], input logic sen, input logic hen);
    logic [N-1:0] es, eh;
    foreach (off[k]) src.ofs[k] = off[k][rfm_pkg::OFS_W-1:0];
    repeat (2 * src.gap + 5) @(posedge clk_i);
    foreach (off[k]) es[k] = alarm(off[k], lim[7:4], sen);
    foreach (off[k]) eh[k] = alarm(off[k], lim[3:0], hen);
    chk(soft_o, es);
    chk(hard_o, eh);
    chk(dq_o, eh);
    wb(0, rfm_pkg::IDX_PAIR_STAT0, 0, q);
    chk(q[3:0], {es[1], eh[1], es[0], eh[0]});
  endtask : alarms
  task automatic pbo_pulses(input int exp);
    int c;
    c = 0;
    repeat (5)
    begin
      @(posedge clk_i);
      #1 c += pbo_o;
    end
    chk(c, exp);
  endtask : pbo_pulses
  int off [N];
  initial
  begin
    #200000;
    err_count++;
    tally_and_finish;
  end
  initial
  begin
    void'($urandom(62));
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    // ========================================================================
    // Reset values, unmapped place, boundary offsets
    wb(0, rfm_pkg::IDX_MON_CTRL, 0, ctl);
    chk(ctl, 8'h05);
    wb(0, rfm_pkg::IDX_ALARM_LIMITS, 0, lim);
    chk(lim, 8'h23);
    wb(1, 8'h7F, 8'hFF, q);
    wb(0, 8'h7F, 0, q);
    chk(q, 8'h00);
    chk(zpl_o, 0);
    foreach (off[k]) off[k] = 0;
    off[0] = 1525; off[1] = -1524; off[2] = 1200; off[3] = -1525;
    alarms(off, 0, 1);
    wb(1, rfm_pkg::IDX_MON_CTRL, 8'h07, q);
    alarms(off, 1, 1);
    // ========================================================================
    // Random limits and offsets, prompt and slow sources
    repeat (12)
    begin
      src.gap = $urandom_range(1, 3);
      lim = 8'($urandom);
      ctl = {5'h0, 1'b1, 2'($urandom)};
      wb(1, rfm_pkg::IDX_ALARM_LIMITS, lim, q);
      wb(1, rfm_pkg::IDX_MON_CTRL, ctl, q);
      wb(0, rfm_pkg::IDX_ALARM_LIMITS, 0, q);
      chk(q, lim);
      foreach (off[k]) off[k] = $urandom_range(0, 12000) - 6000;
      alarms(off, ctl[1], ctl[0]);
    end
    src.gap = 1;
    // ========================================================================
    // Interrupt: clear, raise by a new hard alarm, mask
    wb(1, rfm_pkg::IDX_ALARM_STAT, 8'h07, q);
    wb(1, rfm_pkg::IDX_MON_CTRL, 8'h05, q);
    wb(1, rfm_pkg::IDX_ALARM_LIMITS, 8'h23, q);
    lim = 8'h23;
    foreach (off[k]) off[k] = 0;
    alarms(off, 0, 1);
    wb(1, rfm_pkg::IDX_ALARM_STAT, 8'h07, q);
    wb(0, rfm_pkg::IDX_ALARM_STAT, 0, q);
    chk(q, 8'h00);
    chk(irq_o, 0);
    off[5] = 3000;
    alarms(off, 0, 1);
    wb(0, rfm_pkg::IDX_ALARM_STAT, 0, q);
    chk(q[2], 1);
    // A mask bit of one lets its status bit through to the interrupt
    chk(irq_o, 0);
    wb(1, rfm_pkg::IDX_ALARM_MASK, 8'h07, q);
    chk(irq_o, 1);
    wb(1, rfm_pkg::IDX_ALARM_STAT, 8'h07, q);
    chk(irq_o, 0);
    wb(1, rfm_pkg::IDX_ALARM_MASK, 8'h00, q);
    // ========================================================================
    // Build-out events on switch, holdover exit, free-run exit, then disabled
    src_i <= 4'h3;
    pbo_pulses(1);
    hold_i <= 1;
    repeat (3) @(posedge clk_i);
    hold_i <= 0;
    pbo_pulses(1);
    free_i <= 1;
    repeat (3) @(posedge clk_i);
    free_i <= 0;
    pbo_pulses(1);
    wb(1, rfm_pkg::IDX_MON_CTRL, 8'h01, q);
    repeat (2) @(posedge clk_i);
    chk(zpl_o, 1);
    src_i <= 4'h7;
    pbo_pulses(0);
    tally_and_finish;
  end
endmodule : test_ref_freq_monitor_config
